// ===== hdl/ipv_map.svh
// ipv_map.svh: offsets, field positions, reset values and opcodes of the
// volatile interface/protect configuration register.
// assumes: included by the package, by the core module and by the bench.
`ifndef IPV_MAP_SVH
`define IPV_MAP_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define IPV_OP_READ_CONFIG     8'h35
`define IPV_OP_WRITE_REGS      8'h01
`define IPV_OP_READ_ANY        8'h65
`define IPV_OP_WRITE_ANY       8'h71
`define IPV_OP_OTA_PROGRAM     8'h42

// ----------------------------------------------------------------
// register addresses for the any-register commands (24-bit)
// ----------------------------------------------------------------
`define IPV_ADDR_IPNV          24'h000002
`define IPV_ADDR_IPV           24'h800002
`define IPV_ADDR_CFG2V         24'h800003

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IPV_BIT_LOCK           0
`define IPV_BIT_QUAD           1
`define IPV_BIT_PARAM          2
`define IPV_BIT_SRC            3
`define IPV_BIT_ORIGIN         5
`define IPV_BIT_QPI            6
`define IPV_RO_MASK            8'h2C
`define IPV_RSVD_MASK          8'hD0

// ----------------------------------------------------------------
// reset values and the one-time area window
// ----------------------------------------------------------------
`define IPV_RST_CFG2NV         8'h08
`define IPV_RST_IPNV           8'h00
`define IPV_OTA_LAST           24'h0003FF

`endif

// ===== hdl/ipv_pkg.sv
// ipv_pkg.sv: types shared by the configuration register block.
// assumes: ipv_map.svh lies on the include path.
`include "ipv_map.svh"
package ipv_pkg;

  typedef enum logic [2:0] {
    IPV_ST_CMD   = 3'b000,
    IPV_ST_ADDR  = 3'b001,
    IPV_ST_DATA  = 3'b010,
    IPV_ST_READ  = 3'b011,
    IPV_ST_IDLE  = 3'b100
  } ipv_state_e;

  // one complete register command, handed from the link to the core
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [2:0]  nbytes;
  } ipv_cmd_s;

  // non-volatile state presented by the array side
  typedef struct packed {
    logic [7:0]  ipnv;
    logic [7:0]  cfg2nv;
    logic [2:0]  bp_nv;
  } ipv_nv_s;

endpackage

// ===== hdl/ipv_sync.sv
// ipv_sync.sv: two-flop synchroniser for one level.
// assumes: the input is asynchronous to clk; only the second flop is read.
`timescale 1ns/1ps
module ipv_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      // both pins served here idle high; resetting to that level keeps a
      // false edge out of the cycles after reset
      meta_ff <= 1'b1;
      q       <= 1'b1;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ===== hdl/ipv_core.sv
// ipv_core.sv: volatile interface/protect configuration register with lock.
// assumes: the serial link runs on sck; commands cross to clk_sys when the
// synchronised cs_n rises; non-volatile bits and resets come from the array side.
`timescale 1ns/1ps
`include "ipv_map.svh"
module ipv_core
  import ipv_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            por,
  input  wire logic            soft_rst,
  input  wire logic            sck,
  input  wire logic            cs_n,
  input  wire logic            si,
  input  wire logic            wp_n_pin,
  input  wire ipv_pkg::ipv_nv_s nv,
  output logic                 so,
  output logic [7:0]           interface_protect_volatile,
  output logic [7:0]           interface_config_two_volatile,
  output logic [7:0]           nv_wr_data,
  output logic                 nv_wr_ff,
  output logic [2:0]           bp_nv_wr,
  output logic                 bp_nv_wr_ff,
  output logic [2:0]           bp_vol_ff,
  output logic                 status_write_disable_nv,
  output logic                 prog_err_ff,
  output logic                 ota_prog_ok_ff,
  output logic                 wp_n_eff,
  output logic                 io2_is_data,
  output logic                 io3_is_data
);
  import ipv_pkg::*;

  // ----------------------------------------------------------------
  // link side: shift in one command per chip-select frame
  // ----------------------------------------------------------------
  ipv_state_e  st_ff;
  logic [5:0]  bitcnt_ff;
  logic [7:0]  sh_ff;
  ipv_cmd_s    cmd_ff;
  logic        tog_ff;
  logic [7:0]  rd_shift_ff;
  logic [7:0]  ipv_sys_for_link;

  // the frame ends with cs_n; sck stops outside frames, so counting restarts
  // from the asynchronous chip-select release rather than a trailing edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      st_ff     <= IPV_ST_CMD;
      bitcnt_ff <= 6'h00;
      sh_ff     <= 8'h00;
    end else begin
      sh_ff     <= {sh_ff[6:0], si};
      bitcnt_ff <= bitcnt_ff + 6'h01;
      if (bitcnt_ff[2:0] == 3'h7) begin
        unique case (st_ff)
          IPV_ST_CMD:  st_ff <= IPV_ST_ADDR;
          IPV_ST_ADDR: st_ff <= (bitcnt_ff == 6'h1F) ? IPV_ST_DATA : IPV_ST_ADDR;
          IPV_ST_DATA: st_ff <= IPV_ST_DATA;
          IPV_ST_READ: st_ff <= IPV_ST_READ;
          IPV_ST_IDLE: st_ff <= IPV_ST_IDLE;
        endcase
      end
    end
  end

  // command capture in the link domain; published by the synchronised cs_n release at frame end
  always_ff @(posedge sck) begin
    if (!cs_n && bitcnt_ff[2:0] == 3'h7) begin
      if (bitcnt_ff == 6'h07) begin
        cmd_ff.op     <= {sh_ff[6:0], si};
        cmd_ff.nbytes <= 3'h1;
      end else begin
        cmd_ff.nbytes <= cmd_ff.nbytes + 3'h1;
      end
      if (cmd_ff.op == `IPV_OP_WRITE_REGS && bitcnt_ff != 6'h07) begin
        if (bitcnt_ff == 6'h0F) cmd_ff.d0 <= {sh_ff[6:0], si};
        if (bitcnt_ff == 6'h17) cmd_ff.d1 <= {sh_ff[6:0], si};
      end else if (bitcnt_ff == 6'h0F) begin
        cmd_ff.addr[23:16] <= {sh_ff[6:0], si};
      end else if (bitcnt_ff == 6'h17) begin
        cmd_ff.addr[15:8] <= {sh_ff[6:0], si};
      end else if (bitcnt_ff == 6'h1F) begin
        cmd_ff.addr[7:0] <= {sh_ff[6:0], si};
      end else if (bitcnt_ff == 6'h27) begin
        cmd_ff.d0 <= {sh_ff[6:0], si};
      end
    end
  end

  // read data is a multi-bit value; it is sampled only after the opcode,
  // by which time a prior write has long settled (quasi-static capture)
  always_ff @(negedge sck) begin
    if (bitcnt_ff == 6'h08 && cmd_ff.op == `IPV_OP_READ_CONFIG) begin
      rd_shift_ff <= ipv_sys_for_link;
    end else if (bitcnt_ff == 6'h20 && cmd_ff.op == `IPV_OP_READ_ANY) begin
      rd_shift_ff <= (cmd_ff.addr == `IPV_ADDR_IPV) ? ipv_sys_for_link : 8'h00;
    end else begin
      rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
    end
  end
  assign so = rd_shift_ff[7];

  // ----------------------------------------------------------------
  // crossing: cs_n synchronised into clk_sys; its rising edge marks frame end
  // ----------------------------------------------------------------
  logic cs_sync;
  logic cs_sync_d_ff;
  logic frame_end;

  ipv_sync u_cs_sync (
    .clk (clk_sys),
    .rst (rst),
    .d   (cs_n),
    .q   (cs_sync)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) cs_sync_d_ff <= 1'b1;
    else     cs_sync_d_ff <= cs_sync;
  end
  // command fields are stable from frame end until the next frame starts
  assign frame_end = cs_sync && !cs_sync_d_ff;

  // ----------------------------------------------------------------
  // system side: register state
  // ----------------------------------------------------------------
  logic        lock_ff;
  logic        quad_ff;
  logic        swd_ff;
  logic        is_wrr;
  logic        is_write_any_register_cmd;
  logic        is_ota;
  logic [7:0]  wdata;
  logic        wr_ipv;
  logic        wr_ipnv;
  logic        wr_cfg2v;
  logic        wrr_has_cfg;
  logic [2:0]  bp_nv_cur;

  assign is_wrr      = frame_end && cmd_ff.op == `IPV_OP_WRITE_REGS;
  assign is_write_any_register_cmd     = frame_end && cmd_ff.op == `IPV_OP_WRITE_ANY && cmd_ff.nbytes >= 3'h5;
  assign is_ota      = frame_end && cmd_ff.op == `IPV_OP_OTA_PROGRAM;
  assign wrr_has_cfg = is_wrr && cmd_ff.nbytes >= 3'h3;
  assign wdata       = is_wrr ? cmd_ff.d1 : cmd_ff.d0;
  assign wr_ipv      = wrr_has_cfg || (is_write_any_register_cmd && cmd_ff.addr == `IPV_ADDR_IPV);
  assign wr_ipnv     = wrr_has_cfg || (is_write_any_register_cmd && cmd_ff.addr == `IPV_ADDR_IPNV);
  assign wr_cfg2v    = is_write_any_register_cmd && cmd_ff.addr == `IPV_ADDR_CFG2V;
  assign bp_nv_cur   = nv.bp_nv;

  // lock: power-on reloads it from nv, hardware reset clears it; software reset leaves it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (por) begin
      lock_ff <= nv.ipnv[`IPV_BIT_LOCK];
    end else if (wr_ipv && !lock_ff) begin
      lock_ff <= wdata[`IPV_BIT_LOCK];
    end
  end

  // volatile quad select; never frozen by the lock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      quad_ff <= 1'b0;
    end else if (por || soft_rst) begin
      quad_ff <= nv.ipnv[`IPV_BIT_QUAD];
    end else if (wr_ipv) begin
      if (wdata[`IPV_BIT_QUAD] || !interface_config_two_volatile[`IPV_BIT_QPI]) begin
        quad_ff <= wdata[`IPV_BIT_QUAD];
      end
    end
  end

  // second register volatile copy; power-on and software reset load it from its one-time bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interface_config_two_volatile <= `IPV_RST_CFG2NV;
    end else if (por || soft_rst) begin
      interface_config_two_volatile <= nv.cfg2nv;
    end else if (wr_cfg2v) begin
      interface_config_two_volatile <= cmd_ff.d0;
    end
  end

  // volatile image; read-only shadows follow the non-volatile bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interface_protect_volatile <= 8'h00;
    end else begin
      interface_protect_volatile <= (nv.ipnv & `IPV_RO_MASK)
        | {6'h00, quad_ff, lock_ff};
    end
  end
  assign ipv_sys_for_link = interface_protect_volatile;

  // non-volatile write requests: one-time bits only set, only while unlocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nv_wr_ff   <= 1'b0;
      nv_wr_data <= `IPV_RST_IPNV;
    end else begin
      nv_wr_ff <= wr_ipnv;
      if (wr_ipnv) begin
        nv_wr_data <= lock_ff
          ? ((nv.ipnv & ~8'h02) | (wdata & 8'h02))
          : ((nv.ipnv & 8'h01) | (nv.ipnv & `IPV_RO_MASK)
            | (wdata & (`IPV_RO_MASK | 8'h02)));
      end
    end
  end

  // block-protect and status write-disable from the first status byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bp_vol_ff   <= 3'h0;
      bp_nv_wr_ff <= 1'b0;
      bp_nv_wr    <= 3'h0;
      swd_ff      <= 1'b0;
    end else begin
      bp_nv_wr_ff <= 1'b0;
      if (por || soft_rst) begin
        bp_vol_ff <= bp_nv_cur;
      end else if (is_wrr) begin
        swd_ff <= cmd_ff.d0[7];
        if (!lock_ff) begin
          bp_vol_ff <= cmd_ff.d0[4:2];
          if (!nv.ipnv[`IPV_BIT_SRC]) begin
            bp_nv_wr    <= cmd_ff.d0[4:2];
            bp_nv_wr_ff <= 1'b1;
          end
        end
      end
    end
  end
  assign status_write_disable_nv = swd_ff;

  // one-time area program: fails with error while locked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prog_err_ff    <= 1'b0;
      ota_prog_ok_ff <= 1'b0;
    end else begin
      ota_prog_ok_ff <= 1'b0;
      if (is_ota && cmd_ff.addr <= `IPV_OTA_LAST) begin
        if (lock_ff) prog_err_ff <= 1'b1;
        else         ota_prog_ok_ff <= 1'b1;
      end else if (por || soft_rst) begin
        prog_err_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin function select
  // ----------------------------------------------------------------
  logic wp_sync;

  ipv_sync u_wp_sync (
    .clk (clk_sys),
    .rst (rst),
    .d   (wp_n_pin),
    .q   (wp_sync)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_n_eff    <= 1'b1;
      io2_is_data <= 1'b0;
      io3_is_data <= 1'b0;
    end else begin
      wp_n_eff    <= quad_ff ? 1'b1 : wp_sync;
      io2_is_data <= quad_ff;
      io3_is_data <= quad_ff && !cs_sync;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_lock_holds: assert property (@(posedge clk_sys) disable iff (rst)
    lock_ff && !por |=> lock_ff)
    else $error("lock cleared without power-on");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (interface_protect_volatile & `IPV_RSVD_MASK) == 8'h00)
    else $error("reserved bits not zero");
  a_shadow_follow: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (interface_protect_volatile & `IPV_RO_MASK) == ($past(nv.ipnv) & `IPV_RO_MASK))
    else $error("shadow bits lag non-volatile");
  a_ota_locked: assert property (@(posedge clk_sys) disable iff (rst)
    is_ota && lock_ff && cmd_ff.addr <= `IPV_OTA_LAST |=> prog_err_ff && !ota_prog_ok_ff)
    else $error("locked one-time program not refused");
  a_bp_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    is_wrr && lock_ff && !por && !soft_rst |=> bp_vol_ff == $past(bp_vol_ff) && !bp_nv_wr_ff)
    else $error("block-protect changed under lock");
  a_qpi_quad: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ipv && !wdata[1] && interface_config_two_volatile[6] && quad_ff && !por && !soft_rst
    |=> quad_ff)
    else $error("quad cleared in four-wire mode");
  a_quad_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ipv && wdata[1] && !por && !soft_rst |=> quad_ff ##1 interface_protect_volatile[1])
    else $error("quad write lost");
  a_wp_forced: assert property (@(posedge clk_sys) disable iff (rst)
    quad_ff |=> wp_n_eff && io2_is_data)
    else $error("write-protect not forced inactive");
  a_lock_por: assert property (@(posedge clk_sys) disable iff (rst)
    por |=> lock_ff == $past(nv.ipnv[0]))
    else $error("lock not loaded at power-on");
endmodule

// ===== tb/ipv_host_model.sv
// ipv_host_model.sv: host serial controller that frames register commands.
// assumes: mode 0 link; the device shifts so out on the falling sck edge.
`timescale 1ns/1ps
module ipv_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  real half_ns;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    half_ns = 7.5;
  end

  // ----------------------------------------------------------------
  // one frame, msb first; returns the last eight bits seen on so
  // ----------------------------------------------------------------
  // sck stands still outside frames; si flips after release so that a
  // stale level is never mistaken for a driven one
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = tx[63-i];
      #(half_ns) sck = 1'b1;
      rx = {rx[6:0], so};
      #(half_ns) sck = 1'b0;
    end
    #(half_ns) cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ===== tb/tb.sv
// tb.sv: self-checking bench for the volatile interface/protect register.
// assumes: ipv_map.svh on the include path; host model drives the link.
`timescale 1ns/1ps
`include "ipv_map.svh"
module tb;
  import ipv_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       por = 1'b0;
  logic       soft_rst = 1'b0;
  logic       wp_n_pin = 1'b0;
  ipv_nv_s    nv = {8'h00, 8'h08, 3'h0};
  wire        sck, cs_n, si, so;
  logic [7:0] image, cfg2v, rx;
  logic       swd, perr, wp_eff, io2d;
  logic [7:0] nvwd;
  logic [2:0] bpv, bpnw;
  logic       nvw, bpw, otaok, io3d;
  logic       io3_seen = 1'b0;
  int         ok_cnt = 0;
  int         nvw_cnt = 0;
  int         bpw_cnt = 0;
  int         err_count = 0;
  int         num_checks = 0;
  int         cycles = 0;

  always #25 clk_sys = ~clk_sys;

  ipv_host_model ipv_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

  ipv_core ipv_core_i (
    .clk_sys(clk_sys), .rst(rst), .por(por), .soft_rst(soft_rst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n_pin(wp_n_pin), .nv(nv), .so(so),
    .interface_protect_volatile(image), .interface_config_two_volatile(cfg2v),
    .nv_wr_data(nvwd), .nv_wr_ff(nvw), .bp_nv_wr(bpnw), .bp_nv_wr_ff(bpw), .bp_vol_ff(bpv),
    .status_write_disable_nv(swd), .prog_err_ff(perr), .ota_prog_ok_ff(otaok),
    .wp_n_eff(wp_eff), .io2_is_data(io2d), .io3_is_data(io3d)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang can only come from the link never finishing a frame
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // pulses stand one cycle; the falling edge sees each of them exactly once
  always @(negedge clk_sys) begin
    if (otaok) ok_cnt <= ok_cnt + 1;
    if (nvw) nvw_cnt <= nvw_cnt + 1;
    if (bpw) bpw_cnt <= bpw_cnt + 1;
    if (io3d) io3_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // resets and link commands
  // ----------------------------------------------------------------
  task automatic hw_reset(input logic [7:0] ipnv);
    @(posedge clk_sys);
    rst <= 1'b1;
    nv <= {ipnv, 8'h08, 3'h0};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    por <= 1'b1;
    @(posedge clk_sys);
    por <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // frame then eight idle system cycles, covering the update latency
  task automatic send(input logic [63:0] tx, input int nbits);
    ipv_host_model_i.frame(tx, nbits, rx);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic wr_regs(input logic [7:0] st, input logic [7:0] cfg);
    send({`IPV_OP_WRITE_REGS, st, cfg, 40'h0}, 24);
  endtask

  task automatic wr_any(input logic [23:0] addr, input logic [7:0] d);
    send({`IPV_OP_WRITE_ANY, addr, d, 24'h0}, 40);
  endtask

  task automatic ota_prog(input logic [23:0] addr);
    send({`IPV_OP_OTA_PROGRAM, addr, 8'hA5, 24'h0}, 40);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hw_reset(8'h00);
    chk("image after por", image, 8'h00);
    chk("cfg2 after por", cfg2v, 8'h08);
    chk("wp effective", {7'h0, wp_eff}, 8'h00);
    ota_prog(24'h000010);
    chk("program error unlocked", {7'h0, perr}, 8'h00);
    chk("program accepted", ok_cnt[7:0], 8'h01);
    wr_regs(8'h9C, 8'h2E);
    chk("quad via write regs", image, 8'h02);
    chk("one-time bits writable", nvwd, 8'h2E);
    chk("bp volatile written", {5'h0, bpv}, 8'h07);
    chk("bp nv written", {5'h0, bpnw}, 8'h07);
    chk("nv write pulses", nvw_cnt[7:0], 8'h01);
    chk("bp nv write pulses", bpw_cnt[7:0], 8'h01);
    chk("data3_or_reset_pin role", {7'h0, io3d}, 8'h00);
    chk("write disable", {7'h0, swd}, 8'h01);
    chk("io2 as data", {7'h0, io2d}, 8'h01);
    chk("wp forced high", {7'h0, wp_eff}, 8'h01);
    wr_any(`IPV_ADDR_CFG2V, 8'h48);
    chk("cfg2 write", cfg2v, 8'h48);
    chk("io3 as data in frame", {7'h0, io3_seen}, 8'h01);
    wr_any(`IPV_ADDR_IPV, 8'h00);
    chk("quad clear refused", image, 8'h02);
    wr_any(`IPV_ADDR_CFG2V, 8'h08);
    send({`IPV_OP_READ_CONFIG, 56'h0}, 16);
    chk("config read", rx, 8'h02);
    wr_any(`IPV_ADDR_IPV, 8'hFD);
    chk("lock with other fields", image, 8'h01);
    send({`IPV_OP_READ_ANY, `IPV_ADDR_IPV, 32'h0}, 40);
    chk("read any", rx, 8'h01);
    wr_regs(8'h00, 8'h2E);
    chk("quad under lock", image, 8'h03);
    chk("nv one-time bits frozen", nvwd, 8'h02);
    chk("bp volatile frozen", {5'h0, bpv}, 8'h07);
    chk("bp nv frozen", {5'h0, bpnw}, 8'h07);
    chk("bp nv no write", bpw_cnt[7:0], 8'h01);
    chk("nv quad still written", nvw_cnt[7:0], 8'h02);
    chk("write disable under lock", {7'h0, swd}, 8'h00);
    wr_any(`IPV_ADDR_IPV, 8'h00);
    chk("lock kept", image, 8'h01);
    chk("no error status", {7'h0, perr}, 8'h00);
    ota_prog(24'h000010);
    chk("program error locked", {7'h0, perr}, 8'h01);
    chk("locked program not accepted", ok_cnt[7:0], 8'h01);
    @(posedge clk_sys);
    nv <= {8'h2C, 8'h08, 3'h0};
    repeat (6) @(posedge clk_sys);
    chk("shadows follow", image, 8'h2D);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("soft reset keeps lock", image, 8'h2D);
    wr_any(`IPV_ADDR_CFG2V, 8'h00);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("cfg2 reloaded", cfg2v, 8'h08);
    hw_reset(8'h03);
    chk("lock and quad from nv", image, 8'h03);
    chk("cfg2 after hard reset", cfg2v, 8'h08);
    hw_reset(8'h00);
    chk("hard reset clears lock", image, 8'h00);
    test_done();
  end
endmodule
